// File: src/rish_pkg.sv
// Constants and types shared by the reference switch and holdover logic
package rish_pkg;

    // Selection mode codes
    localparam logic [1:0] RISH_MODE_MANUAL = 2'h0;
    localparam logic [1:0] RISH_MODE_AUTO = 2'h1;
    localparam logic [1:0] RISH_MODE_SHORT_HOLD = 2'h2;
    localparam logic [1:0] RISH_MODE_AUTO_HOLD = 2'h3;

    // Bit of the mode field that marks an automatic mode
    localparam int RISH_MODE_AUTO_BIT = 0;

    // Manual reference choice codes (upper two are reserved)
    localparam logic [1:0] RISH_SEL_INPUT0 = 2'h0;
    localparam logic [1:0] RISH_SEL_INPUT1 = 2'h1;

    // Priority codes
    localparam logic [1:0] RISH_PRIO_NEVER = 2'h0;

    // Reset values of the configuration fields
    localparam logic [1:0] RISH_MODE_RST = RISH_MODE_MANUAL;
    localparam logic [1:0] RISH_SEL_RST = RISH_SEL_INPUT0;
    localparam logic [7:0] RISH_HCNT_RST = 8'h80;
    localparam logic [1:0] RISH_TDIV_RST = 2'h0;
    localparam logic [1:0] RISH_PRIO0_RST = 2'h3;
    localparam logic [1:0] RISH_PRIO1_RST = 2'h2;
    localparam logic RISH_REVERTIVE_SWITCH_ENABLE_RST = 1'b0;

    // Smallest tick divider exponent, for divider code 00
    localparam int RISH_TICK_LOG2_MIN = 15;
    // Divider codes add at most this much to the exponent
    localparam int RISH_TICK_LOG2_SPAN = 3;

    // Hold-off counter figures
    localparam logic [7:0] RISH_HCNT_ONE = 8'h01;
    localparam logic [7:0] RISH_HCNT_ZERO = 8'h00;

    // Automatic selection state machine, Gray coded along the path
    typedef enum logic [1:0] {
        RISH_ST_TRACK = 2'b00,
        RISH_ST_HOLDOFF = 2'b01,
        RISH_ST_FAILOVER = 2'b11
    } rish_state_t;

endpackage

// File: src/rish_tick_div.sv
// Power-of-two tick divider for the hold-off counter
module rish_tick_div
    import rish_pkg::*;
#(
    parameter int BASE_LOG2 = RISH_TICK_LOG2_MIN
) (
    input wire logic clk, // VCXO-derived clock
    input wire logic reset, // Asynchronous, active high
    input wire logic run, // Count while high, clear while low
    input wire logic [1:0] div_code, // Exponent above the base
    output logic tick_q // One-cycle tick
);

    localparam int CNT_W = BASE_LOG2 + RISH_TICK_LOG2_SPAN;

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] span;
    logic [CNT_W-1:0] limit;
    logic at_limit;

    // Period is 2^(base + code) clocks; top code wraps span to zero,
    // leaving limit all ones, which is still the right period
    always_comb begin
        span = CNT_W'(1) << (BASE_LOG2 + int'(div_code));
        limit = span - CNT_W'(1);
        at_limit = (cnt_q >= limit);
    end

    // Cleared while idle so every hold-off starts a full tick period
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_q <= '0;
        end else if (!run || at_limit) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= run && at_limit;
        end
    end

    AST_TICK_SPACING: assert property (@(posedge clk) disable iff (reset)
        tick_q |=> !tick_q)
        else $error("Tick divider produced back-to-back ticks");

endmodule

// File: src/rish_ref_switch.sv
// Reference input selection with automatic failover and hold-off
// Function
// - Mode 00 manual, 01 automatic, 10 short holdover, 11 automatic holdover.
// - Modes 00 and 10 route the manually chosen input to the PLL.
// - Automatic modes pick the reference from loss flags and priorities.
// - A pin-requested selection overrides every mode-derived selection.
// - Manual choice 00 picks input 0, 01 input 1; 10, 11 reserved.
// - Automatic modes ignore the manual choice field.
// - With holdover, failover happens when the hold-off counter reaches zero.
// - The hold-off countdown starts on loss of the selected reference.
// - Counter drops once per divided-clock tick; delay is count times tick, one tick for count 0.
// - Counter reloads from the programmed value after each zero transition.
// - Eight-bit hold-off count resets to 0x80, used only in mode 11.
// - Priority 00 never selected, 11 highest; ties favour input 0. The logic only never switches to it; a selected input set to 00 stays.
// - Revertive switch only when re-validated input outranks current one.
module rish_ref_switch
    import rish_pkg::*;
#(
    parameter int TICK_LOG2_BASE = RISH_TICK_LOG2_MIN
) (
    input wire logic CLK_SYS, // VCXO-derived clock
    input wire logic RESET, // Asynchronous, active high
    input wire logic CFG_WR, // Load all configuration fields
    input wire logic [1:0] CFG_MODE, // Selection mode
    input wire logic [1:0] CFG_MANUAL_SEL, // Manual reference choice
    input wire logic [7:0] CFG_HOLDOFF_COUNT, // Hold-off count
    input wire logic [1:0] CFG_TICK_DIV, // Hold-off tick divider
    input wire logic [1:0] CFG_PRIO0, // Input 0 priority
    input wire logic [1:0] CFG_PRIO1, // Input 1 priority
    input wire logic CFG_REVERT_EN, // Revertive switching enable
    input wire logic [1:0] LOS, // Loss-of-signal per input
    input wire logic PIN_SEL_EN, // Pin selection request
    input wire logic PIN_SEL, // Input requested by the pins
    output logic REF_SEL, // Input routed to the PLL
    output logic REF_USABLE, // Routed input has no loss
    output logic HOLDOFF_ACTIVE, // Hold-off countdown running
    output logic [7:0] HOLDOFF_REMAIN, // Hold-off counter value
    output logic SWITCH_PULSE, // Automatic switch happened
    output logic [1:0] MODE_RB, // Mode readback
    output logic [7:0] HOLDOFF_COUNT_RB // Hold-off count readback
);

    // Configuration registers
    logic [1:0] mode_q;
    logic [1:0] man_sel_q;
    logic [7:0] hcnt_cfg_q;
    logic [1:0] tdiv_q;
    logic [1:0] prio0_q;
    logic [1:0] prio1_q;
    logic revertive_switch_enable_q;

    // Automatic selection state
    rish_state_t state_q;
    logic auto_sel_q;
    logic [7:0] hcnt_q;
    logic switch_q;
    logic [1:0] los_prev_q;
    logic hold_q;

    // Selection outputs
    logic ref_sel_q;
    logic ref_usable_q;

    logic tick;
    logic [1:0] best;
    logic best_ok;
    logic best_idx;
    logic cur_lost;
    logic other;
    logic reval_other;
    logic outranks;
    logic eff_sel;
    logic is_auto;

    // Returns {usable, index}; ties go to input 0
    function automatic logic [1:0] best_ref(input logic [1:0] los,
                                            input logic [1:0] p0,
                                            input logic [1:0] p1);
        logic ok0;
        logic ok1;
        ok0 = !los[0] && (p0 != RISH_PRIO_NEVER);
        ok1 = !los[1] && (p1 != RISH_PRIO_NEVER);
        if (ok0 && (!ok1 || p0 >= p1)) begin
            best_ref = {1'b1, 1'b0};
        end else if (ok1) begin
            best_ref = {1'b1, 1'b1};
        end else begin
            best_ref = {1'b0, 1'b0};
        end
    endfunction

    function automatic logic [1:0] prio_of(input logic idx,
                                           input logic [1:0] p0,
                                           input logic [1:0] p1);
        prio_of = idx ? p1 : p0;
    endfunction

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            mode_q <= RISH_MODE_RST;
            man_sel_q <= RISH_SEL_RST;
            hcnt_cfg_q <= RISH_HCNT_RST;
            tdiv_q <= RISH_TDIV_RST;
            prio0_q <= RISH_PRIO0_RST;
            prio1_q <= RISH_PRIO1_RST;
            revertive_switch_enable_q <= RISH_REVERTIVE_SWITCH_ENABLE_RST;
        end else if (CFG_WR) begin
            mode_q <= CFG_MODE;
            man_sel_q <= CFG_MANUAL_SEL;
            hcnt_cfg_q <= CFG_HOLDOFF_COUNT;
            tdiv_q <= CFG_TICK_DIV;
            prio0_q <= CFG_PRIO0;
            prio1_q <= CFG_PRIO1;
            revertive_switch_enable_q <= CFG_REVERT_EN;
        end
    end

    rish_tick_div #(
        .BASE_LOG2(TICK_LOG2_BASE)
    ) u_tick (
        .clk(CLK_SYS),
        .reset(RESET),
        .run(state_q == RISH_ST_HOLDOFF),
        .div_code(tdiv_q),
        .tick_q(tick)
    );

    always_comb begin
        best = best_ref(LOS, prio0_q, prio1_q);
        best_ok = best[1];
        best_idx = best[0];
        cur_lost = LOS[auto_sel_q];
        other = !auto_sel_q;
        // A loss flag falling on the idle input marks it re-validated
        reval_other = los_prev_q[other] && !LOS[other];
        outranks = prio_of(other, prio0_q, prio1_q) >
                   prio_of(auto_sel_q, prio0_q, prio1_q);
        is_auto = mode_q[RISH_MODE_AUTO_BIT];
    end

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            los_prev_q <= '0;
        end else begin
            los_prev_q <= LOS;
        end
    end

    // Automatic selection state machine
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            state_q <= RISH_ST_TRACK;
            auto_sel_q <= 1'b0;
            hcnt_q <= RISH_HCNT_RST;
            switch_q <= 1'b0;
            hold_q <= 1'b0;
        end else begin
            switch_q <= 1'b0;
            case (state_q)
                RISH_ST_TRACK: begin
                    hcnt_q <= hcnt_cfg_q;
                    if (!is_auto) begin
                        auto_sel_q <= auto_sel_q;
                    end else if (cur_lost &&
                                 mode_q == RISH_MODE_AUTO_HOLD) begin
                        state_q <= RISH_ST_HOLDOFF;
                        hold_q <= 1'b1;
                    end else if (cur_lost) begin
                        if (best_ok && best_idx != auto_sel_q) begin
                            auto_sel_q <= best_idx;
                            switch_q <= 1'b1;
                        end
                    end else if (revertive_switch_enable_q && reval_other && outranks &&
                                 prio_of(other, prio0_q, prio1_q) !=
                                 RISH_PRIO_NEVER) begin
                        auto_sel_q <= other;
                        switch_q <= 1'b1;
                    end
                end
                RISH_ST_HOLDOFF: begin
                    // Leaving mode 11 or getting the signal back aborts
                    if (mode_q != RISH_MODE_AUTO_HOLD || !cur_lost) begin
                        state_q <= RISH_ST_TRACK;
                        hcnt_q <= hcnt_cfg_q;
                        hold_q <= 1'b0;
                    end else if (tick) begin
                        if (hcnt_q <= RISH_HCNT_ONE) begin
                            hcnt_q <= hcnt_cfg_q;
                            state_q <= RISH_ST_FAILOVER;
                            hold_q <= 1'b0;
                        end else begin
                            hcnt_q <= hcnt_q - RISH_HCNT_ONE;
                        end
                    end
                end
                RISH_ST_FAILOVER: begin
                    state_q <= RISH_ST_TRACK;
                    if (best_ok && best_idx != auto_sel_q) begin
                        auto_sel_q <= best_idx;
                        switch_q <= 1'b1;
                    end
                end
                default: begin
                    state_q <= RISH_ST_TRACK;
                    hold_q <= 1'b0;
                    hcnt_q <= hcnt_cfg_q;
                end
            endcase
        end
    end

    // Pins first, then the manual field, then the state machine
    always_comb begin
        if (PIN_SEL_EN) begin
            eff_sel = PIN_SEL;
        end else if (!is_auto) begin
            eff_sel = (man_sel_q == RISH_SEL_INPUT1);
        end else begin
            eff_sel = auto_sel_q;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            ref_sel_q <= 1'b0;
            ref_usable_q <= 1'b0;
        end else begin
            ref_sel_q <= eff_sel;
            ref_usable_q <= !LOS[eff_sel];
        end
    end

    assign REF_SEL = ref_sel_q;
    assign REF_USABLE = ref_usable_q;
    assign HOLDOFF_ACTIVE = hold_q;
    assign HOLDOFF_REMAIN = hcnt_q;
    assign SWITCH_PULSE = switch_q;
    assign MODE_RB = mode_q;
    assign HOLDOFF_COUNT_RB = hcnt_cfg_q;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RESET);

    AST_PIN_OVERRIDE: assert property (
        PIN_SEL_EN |=> REF_SEL == $past(PIN_SEL))
        else $error("Pin selection did not take precedence");

    AST_MANUAL_ROUTE: assert property (
        (!PIN_SEL_EN && !mode_q[RISH_MODE_AUTO_BIT])
        |=> REF_SEL == $past(man_sel_q[0]))
        else $error("Manual mode did not route the chosen input");

    AST_AUTO_IGNORES_MANUAL: assert property (
        (!PIN_SEL_EN && mode_q[RISH_MODE_AUTO_BIT] && $stable(auto_sel_q))
        |=> REF_SEL == $past(auto_sel_q))
        else $error("Automatic mode followed the manual field");

    AST_NOHOLD_IMMEDIATE: assert property (
        (state_q == RISH_ST_TRACK && mode_q == RISH_MODE_AUTO && cur_lost
         && best_ok && best_idx != auto_sel_q)
        |=> auto_sel_q == $past(best_idx) && SWITCH_PULSE)
        else $error("No-holdover mode did not switch at once");

    AST_HOLD_START: assert property (
        (state_q == RISH_ST_TRACK && mode_q == RISH_MODE_AUTO_HOLD &&
         cur_lost)
        |=> HOLDOFF_ACTIVE && hcnt_q == $past(hcnt_cfg_q)
            && auto_sel_q == $past(auto_sel_q))
        else $error("Hold-off did not start with the programmed count");

    AST_HOLD_DECREMENT: assert property (
        (HOLDOFF_ACTIVE && tick && cur_lost && hcnt_q > RISH_HCNT_ONE &&
         mode_q == RISH_MODE_AUTO_HOLD)
        |=> hcnt_q == $past(hcnt_q) - RISH_HCNT_ONE)
        else $error("Hold-off counter did not step by one per tick");

    AST_HOLD_WAIT: assert property (
        (HOLDOFF_ACTIVE && !tick && cur_lost &&
         mode_q == RISH_MODE_AUTO_HOLD)
        |=> hcnt_q == $past(hcnt_q) && auto_sel_q == $past(auto_sel_q))
        else $error("Hold-off counter moved without a tick");

    AST_HOLD_EXPIRE: assert property (
        (HOLDOFF_ACTIVE && tick && cur_lost && hcnt_q <= RISH_HCNT_ONE &&
         mode_q == RISH_MODE_AUTO_HOLD)
        |=> hcnt_q == $past(hcnt_cfg_q) ##1 state_q == RISH_ST_TRACK)
        else $error("Failover or reload missing at zero transition");

    AST_TIE_BREAK: assert property (
        (!LOS[0] && !LOS[1] && prio0_q == prio1_q &&
         prio0_q != RISH_PRIO_NEVER) |-> best_ok && !best_idx)
        else $error("Equal priorities did not favour input 0");

    AST_NEVER_PRIO: assert property (
        SWITCH_PULSE |->
        (auto_sel_q ? $past(prio1_q) : $past(prio0_q)) != RISH_PRIO_NEVER)
        else $error("Priority 00 input was chosen");

    AST_HOLD_FLAG: assert property (
        HOLDOFF_ACTIVE == (state_q == RISH_ST_HOLDOFF))
        else $error("Hold-off flag out of step with the state");

    AST_REVERT_RANK: assert property (
        (state_q == RISH_ST_TRACK && is_auto && !cur_lost && reval_other &&
         !(revertive_switch_enable_q && outranks)) |=> auto_sel_q == $past(auto_sel_q))
        else $error("Revertive switch to a lower-ranked input");

endmodule

// File: verification/rish_ref_switch_tb.sv
// Self-checking bench for the reference switch and hold-off logic
`define CHK(nm, ex, got) begin \
    check_count++; \
    if ((got) !== (ex)) begin \
        failures++; \
        $display("unexpected %s: expected %0h seen %0h", nm, ex, got); \
    end \
end

module rish_ref_switch_tb
    import rish_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // Short tick base keeps each hold-off run to at most 131 cycles
    localparam int BASE = 2;
    typedef struct packed {int start; int delta; logic sel;} rish_note_t;

    logic CLK_SYS = 1'b0;
    logic RESET = 1'b1;
    logic CFG_WR = 1'b0;
    logic [1:0] CFG_MODE = 2'h0;
    logic [1:0] CFG_MANUAL_SEL = 2'h0;
    logic [7:0] CFG_HOLDOFF_COUNT = 8'h80;
    logic [1:0] CFG_TICK_DIV = 2'h0;
    logic [1:0] CFG_PRIO0 = 2'h3;
    logic [1:0] CFG_PRIO1 = 2'h2;
    logic CFG_REVERT_EN = 1'b0;
    logic [1:0] LOS = 2'h0;
    logic PIN_SEL_EN = 1'b0;
    logic PIN_SEL = 1'b0;
    logic REF_SEL, REF_USABLE, HOLDOFF_ACTIVE, SWITCH_PULSE;
    logic [7:0] HOLDOFF_REMAIN, HOLDOFF_COUNT_RB;
    logic [1:0] MODE_RB;
    int failures = 0;
    int check_count = 0;
    int cyc = 0;
    rish_note_t notes[$];
    bit pend = 1'b0;
    logic pend_sel;
    logic cur = 1'b0;
    logic pv;
    logic [7:0] cnt;
    int n_eff;

    rish_ref_switch #(.TICK_LOG2_BASE(BASE)) dut_u (
        .CLK_SYS(CLK_SYS), .RESET(RESET), .CFG_WR(CFG_WR),
        .CFG_MODE(CFG_MODE), .CFG_MANUAL_SEL(CFG_MANUAL_SEL),
        .CFG_HOLDOFF_COUNT(CFG_HOLDOFF_COUNT), .CFG_TICK_DIV(CFG_TICK_DIV),
        .CFG_PRIO0(CFG_PRIO0), .CFG_PRIO1(CFG_PRIO1),
        .CFG_REVERT_EN(CFG_REVERT_EN), .LOS(LOS), .PIN_SEL_EN(PIN_SEL_EN),
        .PIN_SEL(PIN_SEL), .REF_SEL(REF_SEL), .REF_USABLE(REF_USABLE),
        .HOLDOFF_ACTIVE(HOLDOFF_ACTIVE), .HOLDOFF_REMAIN(HOLDOFF_REMAIN),
        .SWITCH_PULSE(SWITCH_PULSE), .MODE_RB(MODE_RB),
        .HOLDOFF_COUNT_RB(HOLDOFF_COUNT_RB)
    );

    always #10 CLK_SYS = ~CLK_SYS;

    task automatic summarize();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge CLK_SYS) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            summarize();
        end
    end

    // Outputs are read on the falling edge, clear of the launch edge
    always @(negedge CLK_SYS) begin
        rish_note_t n;
        if (pend) begin
            `CHK("ref_sel after switch", pend_sel, REF_SEL)
            pend = 1'b0;
        end
        if (SWITCH_PULSE === 1'b1) begin
            if (notes.size() == 0) begin
                `CHK("spurious switch", 1'b0, 1'b1)
            end else begin
                n = notes.pop_front();
                `CHK("switch delay", n.delta, cyc - n.start)
                pend = 1'b1;
                pend_sel = n.sel;
            end
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge CLK_SYS);
    endtask

    task automatic cfg(input logic [1:0] m, input logic [1:0] s,
                       input logic [7:0] c, input logic [1:0] d,
                       input logic [1:0] p1, input logic r);
        @(posedge CLK_SYS);
        CFG_WR <= 1'b1;
        CFG_MODE <= m;
        CFG_MANUAL_SEL <= s;
        CFG_HOLDOFF_COUNT <= c;
        CFG_TICK_DIV <= d;
        CFG_PRIO0 <= 2'h3;
        CFG_PRIO1 <= p1;
        CFG_REVERT_EN <= r;
        @(posedge CLK_SYS);
        CFG_WR <= 1'b0;
        tick(2);
    endtask

    // Drives the loss flags; a nonzero delay notes an expected switch
    task automatic lose(input logic [1:0] l, input int d, input logic s);
        rish_note_t n;
        @(posedge CLK_SYS);
        LOS <= l;
        if (d > 0) begin
            n.start = cyc + 1;
            n.delta = d;
            n.sel = s;
            notes.push_back(n);
        end
    endtask

    task automatic settle();
        for (int i = 0; i < 400 && notes.size() > 0; i++) begin
            @(posedge CLK_SYS);
        end
        `CHK("missing switch", 0, notes.size())
        notes.delete();
        tick(3);
    endtask

    initial begin
        void'($urandom(73));
        tick(16);
        `CHK("mode reset", RISH_MODE_RST, MODE_RB)
        `CHK("count reset", 8'h80, HOLDOFF_COUNT_RB)
        `CHK("remain reset", 8'h80, HOLDOFF_REMAIN)
        RESET <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            cfg(i[2] ? RISH_MODE_SHORT_HOLD : RISH_MODE_MANUAL, {1'b0, i[0]},
                8'h80, 2'h0, 2'h2, 1'b0);
            `CHK("manual ref_sel", i[0], REF_SEL)
            `CHK("ref usable", 1'b1, REF_USABLE)
            `CHK("mode readback", i[2] ? 2'h2 : 2'h0, MODE_RB)
        end
        for (int i = 0; i < 8; i++) begin
            pv = 1'($urandom);
            @(posedge CLK_SYS);
            PIN_SEL_EN <= 1'b1;
            PIN_SEL <= pv;
            cfg(2'($urandom), {1'b0, 1'($urandom)}, 8'h80, 2'h0, 2'h2,
                1'b0);
            `CHK("pin ref_sel", pv, REF_SEL)
        end
        @(posedge CLK_SYS);
        PIN_SEL_EN <= 1'b0;
        cfg(RISH_MODE_AUTO, RISH_SEL_INPUT1, 8'h80, 2'h0, 2'h2, 1'b0);
        `CHK("auto ignores manual", 1'b0, REF_SEL)
        lose(2'h1, 1, 1'b1);
        settle();
        lose(2'h2, 1, 1'b0);
        settle();
        lose(2'h0, 0, 1'b0);
        cfg(RISH_MODE_AUTO, 2'h0, 8'h80, 2'h0, RISH_PRIO_NEVER, 1'b0);
        lose(2'h1, 0, 1'b0);
        tick(10);
        `CHK("never-priority input", 1'b0, REF_SEL)
        `CHK("lost ref unusable", 1'b0, REF_USABLE)
        lose(2'h0, 0, 1'b0);
        for (int d = 0; d < 4; d++) begin
            cnt = 8'($urandom % 5);
            n_eff = (cnt == 8'h00) ? 1 : int'(cnt);
            cfg(RISH_MODE_AUTO_HOLD, 2'h0, cnt, 2'(d), 2'h2, 1'b0);
            `CHK("count readback", cnt, HOLDOFF_COUNT_RB)
            lose(cur ? 2'h2 : 2'h1, n_eff * (1 << (BASE + d)) + 3, ~cur);
            tick(3);
            `CHK("holdoff active", 1'b1, HOLDOFF_ACTIVE)
            settle();
            `CHK("counter reload", cnt, HOLDOFF_REMAIN)
            `CHK("holdoff ended", 1'b0, HOLDOFF_ACTIVE)
            cur = ~cur;
            LOS <= 2'h0;
        end
        cfg(RISH_MODE_AUTO_HOLD, 2'h0, 8'h08, 2'h0, 2'h2, 1'b0);
        lose(cur ? 2'h2 : 2'h1, 0, 1'b0);
        tick(7);
        `CHK("holdoff running", 1'b1, HOLDOFF_ACTIVE)
        `CHK("holdoff step", 8'h07, HOLDOFF_REMAIN)
        lose(2'h0, 0, 1'b0);
        tick(4);
        `CHK("holdoff aborted", 1'b0, HOLDOFF_ACTIVE)
        `CHK("no switch on abort", cur, REF_SEL)
        cfg(RISH_MODE_AUTO, 2'h0, 8'h80, 2'h0, 2'h2, 1'b1);
        lose(2'h1, 1, 1'b1);
        settle();
        lose(2'h0, 1, 1'b0);
        settle();
        `CHK("revert to higher", 1'b0, REF_SEL)
        summarize();
    end
endmodule
